// [verilog/card_suspend_resume_handler.sv]
// How it works
// - P1 bit zero picks suspend or resume.
// - Suspend saves complete session state non-volatile.
// - Refuse suspend 6985 when proactive, channel, secure.
// - Internal reasons may also refuse with 6985.
// - Minimum duration beyond capability gives 9864.
// - Successful suspend stores random eight-byte token.
// - Negotiated maximum lies within proposed range.
// - No 91XX status after successful suspend.
// - Suspend header: P1 P2 zero, Lc 04, Le 0A.
// - Data min then max; reply duration, token.
// - Duration is unit byte then count byte.
// - Resume always erases saved state afterwards.
// - Any other command erases pending saved state, except select not by name, read binary, read record, terminal capability.
// - Resume without saved state gives 6985.
// - Token mismatch on resume gives 6982.
// - Token match restores state, answers 9000.
// - Resume header: P1 01, P2 00, Lc 08.
`include "suspend_resume_cfg.svh"

module card_suspend_resume_handler
    import susp_pkg::*;
#(
    parameter int         STATE_W   = 256,
    parameter logic [7:0] CAP_UNIT  = `UNIT_DAYS,
    parameter logic [7:0] CAP_COUNT = 8'h1E
) (
    input  wire logic               clk,
    input  wire logic               sys_rst,
    input  wire logic               cmd_valid,
    input  wire cmd_class_t         cmd_class,
    input  wire logic [7:0]         cmd_p1,
    input  wire logic [7:0]         cmd_p2,
    input  wire logic [7:0]         cmd_lc,
    input  wire logic               cmd_le_present,
    input  wire logic [7:0]         cmd_le,
    input  wire logic [63:0]        cmd_data,
    input  wire logic               proactive_active,
    input  wire logic               bearer_independent_channel_open,
    input  wire logic               secure_channel_active,
    input  wire logic               internal_refuse,
    input  wire logic [STATE_W-1:0] session_state,
    output logic                    rsp_valid,
    output logic [15:0]             rsp_sw,
    output logic [7:0]              rsp_len,
    output logic [79:0]             rsp_data,
    output logic                    restore_pulse,
    output logic [STATE_W-1:0]      restored_state,
    output logic                    saved_valid,
    output logic                    hold_proactive_sw
);
    saved_state_if #(.STATE_W(STATE_W)) st ();

    saved_state_store #(.STATE_W(STATE_W)) u_store (
        .clk     (clk),
        .sys_rst (sys_rst),
        .st      (st.store)
    );

    logic        is_cmd;
    logic        is_resume;
    logic        hdr_bad;
    logic        allowed_pending;
    logic [7:0]  min_unit;
    logic [7:0]  min_count;
    logic [7:0]  max_unit;
    logic [7:0]  max_count;
    logic [31:0] min_sec;
    logic [31:0] max_sec;
    logic [31:0] cap_sec;
    logic        busy;
    logic        susp_ok;
    logic        token_match;
    logic        next_restore;
    logic [15:0] next_sw;
    logic [7:0]  next_len;
    logic [79:0] next_data;

    assign is_cmd    = cmd_valid && (cmd_class == CMD_SUSPEND_UICC);
    assign is_resume = cmd_p1[`P1_OP_BIT];
    // Reserved P1 bits and P2 must be zero for either operation.
    assign hdr_bad   = (cmd_p1[7:1] != 7'h00) || (cmd_p2 != 8'h00);

    assign min_unit  = cmd_data[63:56];
    assign min_count = cmd_data[55:48];
    assign max_unit  = cmd_data[47:40];
    assign max_count = cmd_data[39:32];
    assign min_sec   = to_seconds(min_unit, min_count);
    assign max_sec   = to_seconds(max_unit, max_count);
    assign cap_sec   = to_seconds(CAP_UNIT, CAP_COUNT);

    // A refusal for internal reasons is left to the card software.
    assign busy = proactive_active || bearer_independent_channel_open ||
                  secure_channel_active || internal_refuse;

    assign token_match = (cmd_data == st.stored_token);

    // Commands that may pass between suspend and resume without loss.
    assign allowed_pending = cmd_valid &&
        (((cmd_class == CMD_SELECT) && (cmd_p1 != `P1_SELECT_BY_NAME)) ||
         (cmd_class == CMD_READ_BINARY) || (cmd_class == CMD_READ_RECORD) ||
         (cmd_class == CMD_TERMINAL_CAPABILITY));

    always_comb begin
        next_sw      = `SW_OK;
        next_len     = `RSP_LEN_NONE;
        next_data    = 80'h0;
        next_restore = 1'b0;
        susp_ok      = 1'b0;
        if (hdr_bad) begin
            next_sw = `SW_WRONG_PARAMS;
        end else if (!is_resume) begin
            if ((cmd_lc != `SUSPEND_LC) || !cmd_le_present ||
                (cmd_le != `SUSPEND_LE)) begin
                next_sw = `SW_WRONG_LENGTH;
            end else if (!unit_ok(min_unit) || !unit_ok(max_unit) ||
                         (min_sec > max_sec)) begin
                next_sw = `SW_BAD_DATA;
            end else if (busy) begin
                next_sw = `SW_COND_NOT_MET;
            end else if (min_sec > cap_sec) begin
                next_sw = `SW_MIN_TOO_LARGE;
            end else begin
                susp_ok  = 1'b1;
                // Success is always plain 9000, never a proactive 91XX.
                next_sw  = `SW_OK;
                next_len = `RSP_LEN_SUSPEND;
                // Offer the terminal's maximum if the card can bear it.
                if (max_sec <= cap_sec) begin
                    next_data[79:64] = {max_unit, max_count};
                end else begin
                    next_data[79:64] = {CAP_UNIT, CAP_COUNT};
                end
                next_data[63:0] = st.fresh_token;
            end
        end else begin
            if ((cmd_lc != `RESUME_LC) || cmd_le_present) begin
                next_sw = `SW_WRONG_LENGTH;
            end else if (!st.valid) begin
                next_sw = `SW_COND_NOT_MET;
            end else if (!token_match) begin
                next_sw = `SW_TOKEN_BAD;
            end else begin
                next_sw      = `SW_OK;
                next_restore = 1'b1;
            end
        end
    end

    assign st.save       = is_cmd && susp_ok;
    assign st.save_state = session_state;
    // A resume of any outcome, and any other command not allowed pending and not a successful suspend, drop the saved state.
    assign st.erase = (is_cmd && is_resume) ||
                      (cmd_valid && !allowed_pending && !st.save);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rsp_valid <= 1'b0;
            rsp_sw    <= `SW_OK;
            rsp_len   <= `RSP_LEN_NONE;
            rsp_data  <= 80'h0;
        end else begin
            rsp_valid <= is_cmd;
            if (is_cmd) begin
                rsp_sw   <= next_sw;
                rsp_len  <= next_len;
                rsp_data <= next_data;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            restore_pulse  <= 1'b0;
            restored_state <= '0;
        end else begin
            restore_pulse <= is_cmd && next_restore;
            if (is_cmd && next_restore) begin
                restored_state <= st.stored_state;
            end
        end
    end

    assign saved_valid = st.valid;
    // The rest of the card must not open a proactive session meanwhile.
    assign hold_proactive_sw = st.valid;

    property p_rsp_follows;
        @(posedge clk) disable iff (sys_rst)
        is_cmd |=> rsp_valid ##1 !rsp_valid || $past(is_cmd);
    endproperty
    a_rsp_follows: assert property (p_rsp_follows)
        else $error("Response did not follow the command.");

    property p_busy_refuse;
        @(posedge clk) disable iff (sys_rst)
        is_cmd && !hdr_bad && !is_resume && busy &&
        (cmd_lc == `SUSPEND_LC) && cmd_le_present &&
        (cmd_le == `SUSPEND_LE) && unit_ok(min_unit) && unit_ok(max_unit) &&
        (min_sec <= max_sec)
        |=> rsp_sw == `SW_COND_NOT_MET && !saved_valid;
    endproperty
    a_busy_refuse: assert property (p_busy_refuse)
        else $error("Busy suspend was not refused with 6985.");

    property p_min_large;
        @(posedge clk) disable iff (sys_rst)
        is_cmd && !is_resume && !busy && (next_sw != `SW_WRONG_PARAMS) &&
        (next_sw != `SW_WRONG_LENGTH) && (next_sw != `SW_BAD_DATA) &&
        (min_sec > cap_sec)
        |=> rsp_sw == `SW_MIN_TOO_LARGE;
    endproperty
    a_min_large: assert property (p_min_large)
        else $error("Oversized minimum duration not refused with 9864.");

    property p_suspend_ok;
        @(posedge clk) disable iff (sys_rst)
        st.save |=> saved_valid && rsp_sw == `SW_OK &&
            rsp_len == `RSP_LEN_SUSPEND &&
            rsp_data[63:0] == st.stored_token;
    endproperty
    a_suspend_ok: assert property (p_suspend_ok)
        else $error("Successful suspend did not store and return token.");

    property p_negotiated;
        @(posedge clk) disable iff (sys_rst)
        st.save |=>
            to_seconds(rsp_data[79:72], rsp_data[71:64]) >= $past(min_sec) &&
            to_seconds(rsp_data[79:72], rsp_data[71:64]) <= $past(max_sec);
    endproperty
    a_negotiated: assert property (p_negotiated)
        else $error("Negotiated duration outside proposed range.");

    property p_no_proactive_sw;
        @(posedge clk) disable iff (sys_rst)
        rsp_valid |-> rsp_sw[15:8] != `SW1_PROACTIVE;
    endproperty
    a_no_proactive_sw: assert property (p_no_proactive_sw)
        else $error("Handler answered with a proactive status word.");

    property p_resume_erase;
        @(posedge clk) disable iff (sys_rst)
        is_cmd && is_resume |=> !saved_valid ##1
            (!saved_valid || $past(st.save));
    endproperty
    a_resume_erase: assert property (p_resume_erase)
        else $error("Saved state survived a resume command.");

    property p_other_erase;
        @(posedge clk) disable iff (sys_rst)
        saved_valid && cmd_valid && !allowed_pending && !is_cmd
        |=> !saved_valid;
    endproperty
    a_other_erase: assert property (p_other_erase)
        else $error("Foreign command did not erase saved state.");

    property p_no_state;
        @(posedge clk) disable iff (sys_rst)
        is_cmd && is_resume && !hdr_bad && !saved_valid &&
        (cmd_lc == `RESUME_LC) && !cmd_le_present
        |=> rsp_sw == `SW_COND_NOT_MET && !restore_pulse;
    endproperty
    a_no_state: assert property (p_no_state)
        else $error("Resume without saved state not refused with 6985.");

    property p_token_bad;
        @(posedge clk) disable iff (sys_rst)
        is_cmd && is_resume && !hdr_bad && saved_valid && !token_match &&
        (cmd_lc == `RESUME_LC) && !cmd_le_present
        |=> rsp_sw == `SW_TOKEN_BAD && !restore_pulse;
    endproperty
    a_token_bad: assert property (p_token_bad)
        else $error("Wrong token not refused with 6982.");

    property p_restore;
        @(posedge clk) disable iff (sys_rst)
        restore_pulse |-> rsp_valid && rsp_sw == `SW_OK &&
            $past(saved_valid) && !saved_valid;
    endproperty
    a_restore: assert property (p_restore)
        else $error("Restore without valid state or 9000.");

    property p_header_refuse;
        @(posedge clk) disable iff (sys_rst)
        is_cmd && hdr_bad |=> rsp_valid && rsp_sw == `SW_WRONG_PARAMS;
    endproperty
    a_header_refuse: assert property (p_header_refuse)
        else $error("Reserved parameter bits were not refused.");

    property p_suspend_len;
        @(posedge clk) disable iff (sys_rst)
        is_cmd && !hdr_bad && !is_resume &&
        ((cmd_lc != `SUSPEND_LC) || !cmd_le_present ||
         (cmd_le != `SUSPEND_LE))
        |=> rsp_sw == `SW_WRONG_LENGTH && !saved_valid;
    endproperty
    a_suspend_len: assert property (p_suspend_len)
        else $error("Malformed suspend header was not refused.");

    property p_resume_len;
        @(posedge clk) disable iff (sys_rst)
        is_cmd && !hdr_bad && is_resume &&
        ((cmd_lc != `RESUME_LC) || cmd_le_present)
        |=> rsp_sw == `SW_WRONG_LENGTH && !restore_pulse && !saved_valid;
    endproperty
    a_resume_len: assert property (p_resume_len)
        else $error("Malformed resume header was not refused.");

    property p_restore_data;
        @(posedge clk) disable iff (sys_rst)
        is_cmd && next_restore |=> restored_state == $past(st.stored_state);
    endproperty
    a_restore_data: assert property (p_restore_data)
        else $error("Restored state differs from the saved state.");
endmodule

// [verilog/suspend_resume_cfg.svh]
`ifndef SUSPEND_RESUME_CFG_SVH
`define SUSPEND_RESUME_CFG_SVH

// Status words.
`define SW_OK              16'h9000
`define SW_COND_NOT_MET    16'h6985
`define SW_TOKEN_BAD       16'h6982
`define SW_MIN_TOO_LARGE   16'h9864
`define SW_WRONG_LENGTH    16'h6700
`define SW_WRONG_PARAMS    16'h6B00
`define SW_BAD_DATA        16'h6A80
`define SW1_PROACTIVE      8'h91

// Command header values.
`define P1_OP_BIT          0
`define P1_SELECT_BY_NAME  8'h04
`define SUSPEND_LC         8'h04
`define SUSPEND_LE         8'h0A
`define RESUME_LC          8'h08
`define RSP_LEN_SUSPEND    8'h0A
`define RSP_LEN_NONE       8'h00

// Duration units and their length in seconds.
`define UNIT_SECONDS       8'h00
`define UNIT_MINUTES       8'h01
`define UNIT_HOURS         8'h02
`define UNIT_DAYS          8'h03
`define UNIT_TEN_DAYS      8'h04
`define SECS_PER_SECOND    32'h0000_0001
`define SECS_PER_MINUTE    32'h0000_003C
`define SECS_PER_HOUR      32'h0000_0E10
`define SECS_PER_DAY       32'h0001_5180
`define SECS_PER_TEN_DAYS  32'h000D_2F00

// Token generator seed; any nonzero value works.
`define TOKEN_SEED         64'h5A5A_0F0F_3C3C_1234

`endif

// [verilog/susp_pkg.sv]
`include "suspend_resume_cfg.svh"

package susp_pkg;

    typedef enum logic [2:0] {
        CMD_SELECT,
        CMD_READ_BINARY,
        CMD_READ_RECORD,
        CMD_TERMINAL_CAPABILITY,
        CMD_SUSPEND_UICC,
        CMD_OTHER
    } cmd_class_t;

    function automatic logic unit_ok(input logic [7:0] unit);
        unit_ok = (unit <= `UNIT_TEN_DAYS);
    endfunction

    function automatic logic [31:0] to_seconds(input logic [7:0] unit,
                                               input logic [7:0] count);
        logic [31:0] mult;
        mult = `SECS_PER_SECOND;
        case (unit)
            `UNIT_MINUTES:  mult = `SECS_PER_MINUTE;
            `UNIT_HOURS:    mult = `SECS_PER_HOUR;
            `UNIT_DAYS:     mult = `SECS_PER_DAY;
            `UNIT_TEN_DAYS: mult = `SECS_PER_TEN_DAYS;
            default:        mult = `SECS_PER_SECOND;
        endcase
        to_seconds = 32'({24'h00_0000, count} * mult);
    endfunction

endpackage

// [verilog/saved_state_if.sv]
interface saved_state_if #(
    parameter int STATE_W = 256
);
    logic               save;
    logic               erase;
    logic [STATE_W-1:0] save_state;
    logic [63:0]        fresh_token;
    logic               valid;
    logic [63:0]        stored_token;
    logic [STATE_W-1:0] stored_state;

    modport handler (
        output save,
        output erase,
        output save_state,
        input  fresh_token,
        input  valid,
        input  stored_token,
        input  stored_state
    );

    modport store (
        input  save,
        input  erase,
        input  save_state,
        output fresh_token,
        output valid,
        output stored_token,
        output stored_state
    );
endinterface

// [verilog/saved_state_store.sv]
`include "suspend_resume_cfg.svh"

module saved_state_store
    import susp_pkg::*;
#(
    parameter int STATE_W = 256
) (
    input  wire logic     clk,
    input  wire logic     sys_rst,
    saved_state_if.store  st
);
    logic [63:0] lfsr;

    // The generator runs every cycle, so the token depends on command timing.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lfsr <= `TOKEN_SEED;
        end else begin
            lfsr <= {lfsr[62:0], lfsr[63] ^ lfsr[62] ^ lfsr[60] ^ lfsr[59]};
        end
    end

    assign st.fresh_token = lfsr;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st.valid <= 1'b0;
        end else if (st.save) begin
            st.valid <= 1'b1;
        end else if (st.erase) begin
            st.valid <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st.stored_token <= 64'h0000_0000_0000_0000;
            st.stored_state <= '0;
        end else if (st.save) begin
            st.stored_token <= lfsr;
            st.stored_state <= st.save_state;
        end
    end
endmodule

// [tb/terminal_host.sv]
`include "suspend_resume_cfg.svh"

module terminal_host
    import susp_pkg::*;
#(
    parameter bit SUSPEND_SUPPORTED = 1'b1
) (
    input  wire logic   clk,
    output logic        cmd_valid,
    output cmd_class_t  cmd_class,
    output logic [7:0]  cmd_p1,
    output logic [7:0]  cmd_p2,
    output logic [7:0]  cmd_lc,
    output logic        cmd_le_present,
    output logic [7:0]  cmd_le,
    output logic [63:0] cmd_data
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        cmd_valid = 1'b0;
        cmd_class = CMD_OTHER;
        cmd_p1 = 8'h00;
        cmd_p2 = 8'h00;
        cmd_lc = 8'h00;
        cmd_le_present = 1'b0;
        cmd_le = 8'h00;
        cmd_data = 64'h0000_0000_0000_0000;
    end

    // One command unit; returns just after the edge that takes it.
    task automatic issue(input cmd_class_t c, input logic [7:0] p1,
                         input logic [7:0] p2, input logic [7:0] lc,
                         input logic lep, input logic [7:0] le,
                         input logic [63:0] d);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_class <= c;
        cmd_p1 <= p1;
        cmd_p2 <= p2;
        cmd_lc <= lc;
        cmd_le_present <= lep;
        cmd_le <= le;
        cmd_data <= d;
        @(posedge clk);
        cmd_valid <= 1'b0;
        // Stale data would let a design that samples late pass.
        cmd_data <= ~d;
        #1;
    endtask

    task automatic suspend(input logic [7:0] mu, input logic [7:0] mc,
                           input logic [7:0] xu, input logic [7:0] xc);
        if (SUSPEND_SUPPORTED) begin
            issue(CMD_SUSPEND_UICC, 8'h00, 8'h00, `SUSPEND_LC, 1'b1,
                  `SUSPEND_LE, {mu, mc, xu, xc, 32'h0000_0000});
        end
    endtask

    // Contacts off after a suspend: the card sees no command meanwhile.
    task automatic deactivate;
        repeat (8) @(posedge clk);
        #1;
    endtask

    task automatic resume(input logic [63:0] tok);
        issue(CMD_SUSPEND_UICC, 8'h01, 8'h00, `RESUME_LC, 1'b0, 8'h00,
              tok);
    endtask

    // Only harmless commands between suspend and resume; the capability
    // command always carries the same content.
    task automatic preamble;
        issue(CMD_TERMINAL_CAPABILITY, 8'h00, 8'h00, 8'h04, 1'b0, 8'h00,
              64'h1234_5678_0000_0000);
        issue(CMD_SELECT, 8'h00, 8'h04, 8'h02, 1'b0, 8'h00,
              64'h3F00_0000_0000_0000);
        issue(CMD_READ_BINARY, 8'h00, 8'h00, 8'h00, 1'b1, 8'h10,
              64'h0000_0000_0000_0000);
        issue(CMD_READ_RECORD, 8'h01, 8'h04, 8'h00, 1'b1, 8'h10,
              64'h0000_0000_0000_0000);
    endtask
endmodule

// [tb/card_suspend_resume_handler_tb_top.sv]
`include "suspend_resume_cfg.svh"

`define CHK(got, exp) begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
        num_errors++; \
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
    end \
end

module card_suspend_resume_handler_tb_top;
    import susp_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [7:0] CAP_U = 8'h03;
    localparam logic [7:0] CAP_C = 8'h1E;

    logic         clk;
    logic         sys_rst;
    logic         cmd_valid;
    cmd_class_t   cmd_class;
    logic [7:0]   cmd_p1;
    logic [7:0]   cmd_p2;
    logic [7:0]   cmd_lc;
    logic         cmd_le_present;
    logic [7:0]   cmd_le;
    logic [63:0]  cmd_data;
    logic [3:0]   busy;
    logic [255:0] session_state;
    logic         rsp_valid;
    logic [15:0]  rsp_sw;
    logic [7:0]   rsp_len;
    logic [79:0]  rsp_data;
    logic         restore_pulse;
    logic [255:0] restored_state;
    logic         saved_valid;
    logic         hold_proactive_sw;
    int           num_errors = 0;
    int           n_checks = 0;
    int           cycles = 0;

    terminal_host host_u (
        .clk(clk), .cmd_valid(cmd_valid), .cmd_class(cmd_class),
        .cmd_p1(cmd_p1), .cmd_p2(cmd_p2), .cmd_lc(cmd_lc),
        .cmd_le_present(cmd_le_present), .cmd_le(cmd_le),
        .cmd_data(cmd_data)
    );

    card_suspend_resume_handler #(.CAP_UNIT(CAP_U), .CAP_COUNT(CAP_C)) dut_u (
        .clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
        .cmd_class(cmd_class), .cmd_p1(cmd_p1), .cmd_p2(cmd_p2),
        .cmd_lc(cmd_lc), .cmd_le_present(cmd_le_present), .cmd_le(cmd_le),
        .cmd_data(cmd_data), .proactive_active(busy[0]),
        .bearer_independent_channel_open(busy[1]),
        .secure_channel_active(busy[2]), .internal_refuse(busy[3]),
        .session_state(session_state), .rsp_valid(rsp_valid),
        .rsp_sw(rsp_sw), .rsp_len(rsp_len), .rsp_data(rsp_data),
        .restore_pulse(restore_pulse), .restored_state(restored_state),
        .saved_valid(saved_valid), .hold_proactive_sw(hold_proactive_sw)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    function automatic longint secs(input logic [7:0] u, input logic [7:0] c);
        longint m[5] = '{32'h0000_0001, 32'h0000_003C, 32'h0000_0E10,
                         32'h0001_5180, 32'h000D_2F00};
        return m[u] * c;
    endfunction

    task automatic final_report;
        $display("checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Every unit code, then a maximum beyond the card's own limit.
    task automatic t_units;
        logic [15:0] exp;
        for (int u = 0; u < 5; u++) begin
            host_u.suspend(8'(u), 8'h01, 8'(u), 8'h02);
            exp = (secs(8'(u), 8'h02) <= secs(CAP_U, CAP_C)) ?
                  {8'(u), 8'h02} : {CAP_U, CAP_C};
            `CHK(rsp_valid, 1'b1);
            `CHK(rsp_sw, `SW_OK);
            `CHK(rsp_data[79:64], exp);
            `CHK(rsp_len, 8'h0A);
            `CHK(hold_proactive_sw, 1'b1);
        end
        host_u.suspend(8'h03, 8'h01, 8'h04, 8'h09);
        `CHK(rsp_data[79:64], {CAP_U, CAP_C});
    endtask

    task automatic t_resume_ok;
        logic [63:0] tok;
        @(posedge clk);
        session_state <= {8{32'hA5A5_0001}};
        host_u.suspend(8'h00, 8'h05, 8'h01, 8'h02);
        tok = rsp_data[63:0];
        `CHK(saved_valid, 1'b1);
        host_u.deactivate();
        `CHK(saved_valid, 1'b1);
        @(posedge clk);
        session_state <= {8{32'h0F0F_7777}};
        host_u.preamble();
        `CHK(saved_valid, 1'b1);
        host_u.resume(tok);
        `CHK(rsp_sw, `SW_OK);
        `CHK(restore_pulse, 1'b1);
        `CHK(restored_state, {8{32'hA5A5_0001}});
        `CHK(saved_valid, 1'b0);
        `CHK(hold_proactive_sw, 1'b0);
        @(posedge clk);
        #1;
        `CHK(restore_pulse, 1'b0);
    endtask

    task automatic t_bad_token;
        logic [63:0] tok;
        host_u.suspend(8'h00, 8'h05, 8'h00, 8'h3C);
        tok = rsp_data[63:0];
        host_u.resume(tok ^ 64'h0000_0000_0000_0001);
        `CHK(rsp_sw, `SW_TOKEN_BAD);
        `CHK(restore_pulse, 1'b0);
        `CHK(saved_valid, 1'b0);
        host_u.resume(tok);
        `CHK(rsp_sw, `SW_COND_NOT_MET);
    endtask

    // Each busy source alone must refuse; the refusal drops old state.
    task automatic t_busy;
        for (int i = 0; i < 4; i++) begin
            host_u.suspend(8'h00, 8'h01, 8'h00, 8'h02);
            @(posedge clk);
            busy <= 4'(1 << i);
            host_u.suspend(8'h00, 8'h01, 8'h00, 8'h02);
            `CHK(rsp_sw, `SW_COND_NOT_MET);
            `CHK(saved_valid, 1'b0);
            @(posedge clk);
            busy <= 4'h0;
        end
        host_u.suspend(8'h04, 8'h04, 8'h04, 8'h05);
        `CHK(rsp_sw, `SW_MIN_TOO_LARGE);
        `CHK(rsp_len, 8'h00);
    endtask

    task automatic t_erase;
        host_u.suspend(8'h00, 8'h01, 8'h00, 8'h02);
        host_u.issue(CMD_OTHER, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00, 64'h0);
        `CHK(rsp_valid, 1'b0);
        `CHK(saved_valid, 1'b0);
        host_u.suspend(8'h00, 8'h01, 8'h00, 8'h02);
        host_u.issue(CMD_SELECT, 8'h04, 8'h04, 8'h02, 1'b0, 8'h00, 64'h0);
        `CHK(saved_valid, 1'b0);
        host_u.issue(CMD_SUSPEND_UICC, 8'h02, 8'h00, 8'h04, 1'b1, 8'h0A,
                     64'h0001_0002_0000_0000);
        `CHK(rsp_sw, `SW_WRONG_PARAMS);
        host_u.issue(CMD_SUSPEND_UICC, 8'h00, 8'h00, 8'h05, 1'b1, 8'h0A,
                     64'h0001_0002_0000_0000);
        `CHK(rsp_sw, `SW_WRONG_LENGTH);
        host_u.issue(CMD_SUSPEND_UICC, 8'h01, 8'h00, 8'h08, 1'b1, 8'h00,
                     64'h0);
        `CHK(rsp_sw, `SW_WRONG_LENGTH);
        host_u.suspend(8'h05, 8'h01, 8'h00, 8'h02);
        `CHK(rsp_sw, `SW_BAD_DATA);
        host_u.suspend(8'h01, 8'h02, 8'h00, 8'h3C);
        `CHK(rsp_sw, `SW_BAD_DATA);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            final_report();
        end
    end

    initial begin
        sys_rst = 1'b1;
        busy = 4'h0;
        session_state = {8{32'h1111_2222}};
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        `CHK(rsp_sw, `SW_OK);
        `CHK(saved_valid, 1'b0);
        t_units();
        t_resume_ok();
        t_bad_token();
        t_busy();
        t_erase();
        final_report();
    end
endmodule
